// >>> hw/pld_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * phase-detector control and lock-detect block.
 * Assumes: included by bare name; definitions only.
 */
`ifndef PLD_REGS_SVH
`define PLD_REGS_SVH

// Register offsets, byte addresses on the 9-bit register port
`define PLD_OFS_PD_CTRL 9'h15b
`define PLD_OFS_CNT_HI 9'h15c
`define PLD_OFS_CNT_LO 9'h15d
`define PLD_OFS_LD_CFG 9'h15f
`define PLD_OFS_STATUS 9'h1e0
`define PLD_OFS_RUN_HI 9'h1e1
`define PLD_OFS_RUN_LO 9'h1e2

// Field positions in the phase-detector control register
`define PLD_WND_MSB 7
`define PLD_WND_LSB 6
`define PLD_HIZ_BIT 5
`define PLD_POL_BIT 4
`define PLD_CUR_MSB 3
`define PLD_CUR_LSB 0
// Field positions in the count and status-pin registers
`define PLD_CNT_HI_MSB 5
`define PLD_SRC_MSB 7
`define PLD_SRC_LSB 3
`define PLD_TYPE_MSB 2
`define PLD_TYPE_LSB 0

// Reset values
`define PLD_RST_WND 2'h3
`define PLD_RST_HIZ 1'h0
`define PLD_RST_POL 1'h1
`define PLD_RST_CUR 4'h4
`define PLD_RST_CNT_HI 6'h20
`define PLD_RST_CNT_LO 8'h00
`define PLD_RST_SRC 5'h01
`define PLD_RST_TYPE 3'h6

// Status pin source and drive type codes
`define PLD_SRC_LOW 5'h00
`define PLD_SRC_LOCK 5'h01
`define PLD_TYPE_PP 3'h3
`define PLD_TYPE_PP_INV 3'h4
`define PLD_TYPE_OD 3'h6

// Charge pump current: base plus step per code, in microamps
`define PLD_CP_BASE_UA 11'h032
`define PLD_CP_STEP_UA 11'h064

// Window widths in ns and the core clock rate
`define PLD_CLK_MHZ 25
`define PLD_WND0_NS 4
`define PLD_WND1_NS 9
`define PLD_WND2_NS 19
`define PLD_WND3_NS 43
// Longest time: rounds down, never below one cycle
`define PLD_CYC(ns) ((((ns) * `PLD_CLK_MHZ) / 1000) < 1 ? 1 : (((ns) * `PLD_CLK_MHZ) / 1000))

`endif

// >>> hw/pld_pkg.sv
/*
 * Types and shared functions of the lock-detect block.
 * Assumes: pld_regs.svh on the include path.
 */
package pld_pkg;
`include "pld_regs.svh"

    // Which phase-detector edge arrived first
    typedef enum logic [1:0] {PLD_IDLE, PLD_REF_LEAD, PLD_FB_LEAD} pld_phase_e;

    // One finished phase comparison
    typedef struct packed {
        logic valid;
        logic in_window;
    } pld_cmp_s;

    // State of the phase window meter
    typedef struct packed {
        pld_phase_e phase;
        logic [7:0] cnt;
        pld_cmp_s cmp;
    } pld_meas_state_s;

    // State of the top block
    typedef struct packed {
        logic [1:0] wnd;
        logic hiz;
        logic pol;
        logic [3:0] cur;
        logic [5:0] cnt_hi;
        logic [7:0] cnt_lo;
        logic [4:0] src;
        logic [2:0] pin_type;
        logic [13:0] run_cnt;
        logic lock;
        logic last_in;
        logic [7:0] rd_data;
        logic [10:0] cp_ua;
        logic cp_oe;
        logic pin_o;
        logic pin_oe;
    } pld_state_s;

    // Window code to whole core cycles
    function automatic logic [7:0] pld_win_cycles(input logic [1:0] code);
        case (code)
            2'h0: pld_win_cycles = 8'(`PLD_CYC(`PLD_WND0_NS));
            2'h1: pld_win_cycles = 8'(`PLD_CYC(`PLD_WND1_NS));
            2'h2: pld_win_cycles = 8'(`PLD_CYC(`PLD_WND2_NS));
            default: pld_win_cycles = 8'(`PLD_CYC(`PLD_WND3_NS));
        endcase
    endfunction : pld_win_cycles

    // Current code to microamps
    function automatic logic [10:0] pld_cp_ua(input logic [3:0] code);
        pld_cp_ua = 11'(`PLD_CP_BASE_UA + `PLD_CP_STEP_UA * {7'h00, code});
    endfunction : pld_cp_ua
endpackage : pld_pkg

// >>> hw/pld_phase_window.sv
/*
 * Phase window meter: times the gap between a reference edge and a feedback
 * edge and reports one comparison per pair.
 * Assumes: edge inputs are one-cycle pulses synchronous to clk.
 */
`timescale 1ns/1ns
module pld_phase_window import pld_pkg::*; #(
    parameter int CNT_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ref_edge,
    input wire logic fb_edge,
    input wire logic [CNT_W-1:0] win_cycles,
    output pld_cmp_s cmp
);
    pld_meas_state_s st; // Registered state
    pld_meas_state_s next_st; // Next state

    // Pair edges; a repeated lead edge without its partner is a miss
    always_comb begin
        logic lead_hit;
        logic lag_hit;
        lead_hit = 1'b0;
        lag_hit = 1'b0;
        next_st = st;
        next_st.cmp = '0;
        case (st.phase)
            PLD_IDLE: begin
                if (ref_edge && fb_edge) begin
                    next_st.cmp = '{valid: 1'b1, in_window: 1'b1};
                end else if (ref_edge) begin
                    next_st.phase = PLD_REF_LEAD;
                    next_st.cnt = '0;
                end else if (fb_edge) begin
                    next_st.phase = PLD_FB_LEAD;
                    next_st.cnt = '0;
                end
            end
            PLD_REF_LEAD, PLD_FB_LEAD: begin
                lead_hit = (st.phase == PLD_REF_LEAD) ? ref_edge : fb_edge;
                lag_hit = (st.phase == PLD_REF_LEAD) ? fb_edge : ref_edge;
                // Saturate so a lost partner cannot wrap back into the window
                if (st.cnt != '1) begin
                    next_st.cnt = st.cnt + 8'h01;
                end
                if (lag_hit) begin
                    next_st.cmp.valid = 1'b1;
                    next_st.cmp.in_window = (st.cnt < win_cycles);
                    next_st.phase = PLD_IDLE;
                    // A fresh lead edge in the same cycle opens the next pair
                    if (lead_hit) begin
                        next_st.phase = st.phase;
                        next_st.cnt = '0;
                    end
                end else if (lead_hit) begin
                    next_st.cmp = '{valid: 1'b1, in_window: 1'b0};
                    next_st.cnt = '0;
                end
            end
            default: begin
                next_st.phase = PLD_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{phase: PLD_IDLE, cnt: '0, cmp: '0};
        end else begin
            st <= next_st;
        end
    end

    assign cmp = st.cmp;
endmodule : pld_phase_window

// >>> hw/pld_top.sv
/*
 * Phase-detector control register and digital lock detect of the first loop:
 * register port, lock qualify counter, charge pump controls, status pin.
 * Assumes: one 25 MHz clock; edge inputs and the register port are
 * synchronous to it; the status pin wire is resolved outside.
 */
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
`include "pld_regs.svh"

module pld_top import pld_pkg::*; #(
    parameter int ADDR_W = 9,
    parameter int CNT_W = 14
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [7:0] RD_DATA,
    input wire logic REF_EDGE,
    input wire logic FB_EDGE,
    output logic CHARGE_PUMP_OUT_PIN_OE,
    output logic CHARGE_PUMP_POLARITY_SEL,
    output logic [3:0] CHARGE_PUMP_CURRENT_SEL,
    output logic [10:0] CHARGE_PUMP_CURRENT_UA,
    output logic DIGITAL_LOCK_FLAG,
    input wire logic LOCK_STATUS_PIN_I,
    output logic LOCK_STATUS_PIN_O,
    output logic LOCK_STATUS_PIN_OE
);
    // Reset image of the whole state
    localparam pld_state_s RST_STATE = '{
        wnd: `PLD_RST_WND,
        hiz: `PLD_RST_HIZ,
        pol: `PLD_RST_POL,
        cur: `PLD_RST_CUR,
        cnt_hi: `PLD_RST_CNT_HI,
        cnt_lo: `PLD_RST_CNT_LO,
        src: `PLD_RST_SRC,
        pin_type: `PLD_RST_TYPE,
        run_cnt: 14'h0000,
        lock: 1'b0,
        last_in: 1'b0,
        rd_data: 8'h00,
        cp_ua: 11'h1c2,
        cp_oe: 1'b1,
        pin_o: 1'b0,
        pin_oe: 1'b0
    };

    pld_state_s st; // Registered state
    pld_state_s next_st; // Next state
    pld_cmp_s cmp; // One comparison result from the meter
    logic [7:0] win_cycles; // Allowed phase error in core cycles

    // Window code to cycles; at 40 ns per cycle every code maps to one cycle
    assign win_cycles = pld_win_cycles(st.wnd);

    // Edge pairing and phase error timing
    pld_phase_window #(
        .CNT_W(8)
    ) u_meter (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .ref_edge(REF_EDGE),
        .fb_edge(FB_EDGE),
        .win_cycles(win_cycles),
        .cmp(cmp)
    );

    // Register port, lock counter and pin drive
    always_comb begin
        logic [CNT_W-1:0] target;
        logic lock_src;
        target = {st.cnt_hi, st.cnt_lo};
        lock_src = 1'b0;
        next_st = st;

        // Register writes take effect on the next edge
        if (WR_STB) begin
            case (ADDR)
                `PLD_OFS_PD_CTRL: begin
                    next_st.wnd = WR_DATA[`PLD_WND_MSB:`PLD_WND_LSB];
                    next_st.hiz = WR_DATA[`PLD_HIZ_BIT];
                    next_st.pol = WR_DATA[`PLD_POL_BIT];
                    next_st.cur = WR_DATA[`PLD_CUR_MSB:`PLD_CUR_LSB];
                end
                `PLD_OFS_CNT_HI: begin
                    next_st.cnt_hi = WR_DATA[`PLD_CNT_HI_MSB:0];
                end
                `PLD_OFS_CNT_LO: begin
                    next_st.cnt_lo = WR_DATA;
                end
                `PLD_OFS_LD_CFG: begin
                    next_st.src = WR_DATA[`PLD_SRC_MSB:`PLD_SRC_LSB];
                    next_st.pin_type = WR_DATA[`PLD_TYPE_MSB:`PLD_TYPE_LSB];
                end
                default: begin
                    // Writes elsewhere and to read-only words are dropped
                end
            endcase
        end

        // Read data stand only in the cycle after the strobe
        next_st.rd_data = 8'h00;
        if (RD_STB) begin
            case (ADDR)
                `PLD_OFS_PD_CTRL: begin
                    next_st.rd_data = {st.wnd, st.hiz, st.pol, st.cur};
                end
                `PLD_OFS_CNT_HI: begin
                    next_st.rd_data = {2'h0, st.cnt_hi};
                end
                `PLD_OFS_CNT_LO: begin
                    next_st.rd_data = st.cnt_lo;
                end
                `PLD_OFS_LD_CFG: begin
                    next_st.rd_data = {st.src, st.pin_type};
                end
                `PLD_OFS_STATUS: begin
                    // Pin level lets software see an open-drain wire held low
                    next_st.rd_data = {5'h00, LOCK_STATUS_PIN_I, st.last_in, st.lock};
                end
                `PLD_OFS_RUN_HI: begin
                    next_st.rd_data = {2'h0, st.run_cnt[13:8]};
                end
                `PLD_OFS_RUN_LO: begin
                    next_st.rd_data = st.run_cnt[7:0];
                end
                default: begin
                    next_st.rd_data = 8'h00; // Unmapped reads return zero
                end
            endcase
        end

        // Lock qualification, one step per finished comparison
        if (cmp.valid) begin
            next_st.last_in = cmp.in_window;
            if (cmp.in_window) begin
                // Saturate at the target so a long lock cannot wrap
                if (st.run_cnt < target) begin
                    next_st.run_cnt = st.run_cnt + 14'h0001;
                end
                // Zero target is reserved and never grants lock
                if (target != '0 && st.run_cnt + 14'h0001 >= target) begin
                    next_st.lock = 1'b1;
                end
            end else begin
                next_st.run_cnt = '0;
                next_st.lock = 1'b0;
            end
        end

        // Charge pump controls change on the same edge as the control register
        next_st.cp_oe = ~next_st.hiz;
        next_st.cp_ua = pld_cp_ua(next_st.cur);

        // Status pin source; unsupported sources read as low
        case (next_st.src)
            `PLD_SRC_LOCK: begin
                lock_src = next_st.lock;
            end
            `PLD_SRC_LOW: begin
                lock_src = 1'b0;
            end
            default: begin
                lock_src = 1'b0;
            end
        endcase

        // Status pin drive type; reserved types leave the pin undriven
        case (next_st.pin_type)
            `PLD_TYPE_PP: begin
                next_st.pin_o = lock_src;
                next_st.pin_oe = 1'b1;
            end
            `PLD_TYPE_PP_INV: begin
                next_st.pin_o = ~lock_src;
                next_st.pin_oe = 1'b1;
            end
            `PLD_TYPE_OD: begin
                // Open drain: only ever pull low, the pull-up gives the high
                next_st.pin_o = 1'b0;
                next_st.pin_oe = ~lock_src;
            end
            default: begin
                next_st.pin_o = 1'b0;
                next_st.pin_oe = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st <= RST_STATE;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign RD_DATA = st.rd_data;
    assign CHARGE_PUMP_OUT_PIN_OE = st.cp_oe;
    assign CHARGE_PUMP_POLARITY_SEL = st.pol;
    assign CHARGE_PUMP_CURRENT_SEL = st.cur;
    assign CHARGE_PUMP_CURRENT_UA = st.cp_ua;
    assign DIGITAL_LOCK_FLAG = st.lock;
    assign LOCK_STATUS_PIN_O = st.pin_o;
    assign LOCK_STATUS_PIN_OE = st.pin_oe;
endmodule : pld_top

// >>> tb/pld_top_asserts.sv
/*
 * Checker for the lock-detect block: register side effects and lock timing.
 * Assumes: bound to pld_top; sees only its ports.
 */
`timescale 1ns/1ns
module pld_top_asserts #(
    parameter int ADDR_W = 9,
    parameter int CNT_W = 14
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    input wire logic [7:0] RD_DATA,
    input wire logic REF_EDGE,
    input wire logic FB_EDGE,
    input wire logic CHARGE_PUMP_OUT_PIN_OE,
    input wire logic CHARGE_PUMP_POLARITY_SEL,
    input wire logic [3:0] CHARGE_PUMP_CURRENT_SEL,
    input wire logic [10:0] CHARGE_PUMP_CURRENT_UA,
    input wire logic DIGITAL_LOCK_FLAG
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    // Write and read of the control register
    sequence s_wr_ctrl;
        WR_STB && ADDR == 9'h15b;
    endsequence
    sequence s_rd_ctrl;
        RD_STB && ADDR == 9'h15b;
    endsequence
    a_cp_hiz: assert property (s_wr_ctrl |=> CHARGE_PUMP_OUT_PIN_OE == !$past(WR_DATA[5]))
        else $error("charge pump enable wrong after write");
    a_cp_pol: assert property (s_wr_ctrl |=> CHARGE_PUMP_POLARITY_SEL == $past(WR_DATA[4]))
        else $error("charge pump polarity wrong after write");
    a_cp_code: assert property (s_wr_ctrl |=> CHARGE_PUMP_CURRENT_SEL == $past(WR_DATA[3:0]))
        else $error("charge pump code wrong after write");
    a_cp_ua: assert property (CHARGE_PUMP_CURRENT_UA == 11'h032 + 11'h064 * {7'h00, CHARGE_PUMP_CURRENT_SEL})
        else $error("charge pump current not base plus steps");
    a_rd_ctrl: assert property (s_rd_ctrl |=> RD_DATA[5:0] == {!CHARGE_PUMP_OUT_PIN_OE, CHARGE_PUMP_POLARITY_SEL, CHARGE_PUMP_CURRENT_SEL})
        else $error("control readback differs from pins");
    // Lock only moves two edges after a phase edge closes a comparison
    a_lock_rise: assert property ($rose(DIGITAL_LOCK_FLAG) |-> $past(REF_EDGE || FB_EDGE, 2))
        else $error("lock rose without a comparison");
    a_lock_fall: assert property ($fell(DIGITAL_LOCK_FLAG) |-> $past(REF_EDGE || FB_EDGE, 2))
        else $error("lock fell without a comparison");
    a_lock_hold: assert property (!$past(REF_EDGE || FB_EDGE, 2) |-> $stable(DIGITAL_LOCK_FLAG))
        else $error("lock moved between comparisons");
endmodule : pld_top_asserts

bind pld_top pld_top_asserts #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) pld_top_asserts_inst (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_STB(WR_STB),
    .RD_STB(RD_STB), .RD_DATA(RD_DATA), .REF_EDGE(REF_EDGE), .FB_EDGE(FB_EDGE),
    .CHARGE_PUMP_OUT_PIN_OE(CHARGE_PUMP_OUT_PIN_OE),
    .CHARGE_PUMP_POLARITY_SEL(CHARGE_PUMP_POLARITY_SEL),
    .CHARGE_PUMP_CURRENT_SEL(CHARGE_PUMP_CURRENT_SEL),
    .CHARGE_PUMP_CURRENT_UA(CHARGE_PUMP_CURRENT_UA), .DIGITAL_LOCK_FLAG(DIGITAL_LOCK_FLAG));

// >>> tb/pld_loop_model.sv
/*
 * Reference and feedback edge source: one pair every 8 cycles, lag set by gap.
 * Assumes: gap below 8; edges quiet while run is low.
 */
`timescale 1ns/1ns
module pld_loop_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [2:0] gap,
    output logic ref_edge,
    output logic fb_edge
);
    logic [2:0] ph; // Position in the 8-cycle pair slot
    // Gap 0 gives coincident edges, the zero-error case
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph <= 3'h0;
            ref_edge <= 1'b0;
            fb_edge <= 1'b0;
        end else if (!run) begin
            // Quiet between bursts so every burst starts a fresh slot
            ph <= 3'h0;
            ref_edge <= 1'b0;
            fb_edge <= 1'b0;
        end else begin
            ph <= ph + 3'h1;
            ref_edge <= (ph == 3'h0);
            fb_edge <= (ph == gap);
        end
    end
endmodule : pld_loop_model

// >>> tb/pld_top_test.sv
/*
 * Self-checking bench: registers, charge pump pins, lock qualify, status pin.
 * Assumes: open-drain status wire with a pull-up; read data checked via queue.
 */
`timescale 1ns/1ns
module pld_top_test;
    logic clk = 0, rst_n = 0, wr_stb = 0, rd_stb = 0, run = 0, rd_pend = 0;
    logic [8:0] addr = 0;
    logic [7:0] wr_data = 0, d, rd_data, exp_q[$];
    logic [2:0] gap = 0;
    logic ref_e, fb_e, oe, pol, lock, pin_o, pin_oe;
    logic [3:0] cur;
    logic [10:0] ua;
    logic [31:0] seed = 32'h2d; // Xorshift state
    int error_cnt = 0, total_checks = 0;
    wire logic pin_i = pin_oe ? pin_o : 1'b1; // Pull-up when nobody drives
    initial forever #20 clk = ~clk;
    pld_top pld_top_inst (.CORE_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WR_DATA(wr_data),
        .WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data), .REF_EDGE(ref_e), .FB_EDGE(fb_e),
        .CHARGE_PUMP_OUT_PIN_OE(oe), .CHARGE_PUMP_POLARITY_SEL(pol),
        .CHARGE_PUMP_CURRENT_SEL(cur), .CHARGE_PUMP_CURRENT_UA(ua), .DIGITAL_LOCK_FLAG(lock),
        .LOCK_STATUS_PIN_I(pin_i), .LOCK_STATUS_PIN_O(pin_o), .LOCK_STATUS_PIN_OE(pin_oe));
    pld_loop_model pld_loop_model_inst (.clk(clk), .rst_n(rst_n), .run(run), .gap(gap),
        .ref_edge(ref_e), .fb_edge(fb_e));
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        xs = seed;
    endfunction : xs
    task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task wr(input logic [8:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wr_data <= v;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask : wr
    // Expected read data is noted before the answer can appear
    task rd(input logic [8:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd_stb <= 1'b0;
    endtask : rd
    // Exactly n pairs, then time for the lock update to land
    task run_pairs(input int n, input logic [2:0] g);
        @(posedge clk);
        gap <= g;
        run <= 1'b1;
        repeat (8 * n) @(posedge clk);
        run <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask : run_pairs
    task stop_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    // Read data stands only in the cycle after the strobe
    always @(posedge clk) rd_pend <= rd_stb;
    always @(negedge clk) if (rd_pend) chk("rd_data", 11'(exp_q.pop_front()), 11'(rd_data));
    // Hang guard, far above the scripted run
    initial begin
        #1000000;
        error_cnt++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(9'h15b, 8'hd4);
        rd(9'h15c, 8'h20);
        rd(9'h15d, 8'h00);
        rd(9'h100, 8'h00);
        @(negedge clk);
        chk("cp_oe", 11'h1, 11'(oe));
        chk("cp_pol", 11'h1, 11'(pol));
        chk("cp_ua", 11'h1c2, ua);
        chk("pin_oe", 11'h1, 11'(pin_oe));
        $display("test reset done");
        // Random control values, every window code once
        for (int i = 0; i < 4; i++) begin
            d = 8'(xs());
            d[7:6] = 2'(i);
            wr(9'h15b, d);
            rd(9'h15b, d);
            @(negedge clk);
            chk("cp_oe", 11'(!d[5]), 11'(oe));
            chk("cp_pol", 11'(d[4]), 11'(pol));
            chk("cp_cur", 11'(d[3:0]), 11'(cur));
            chk("cp_ua", 11'h032 + 11'h064 * {7'h00, d[3:0]}, ua);
        end
        $display("test control done");
        wr(9'h15c, 8'h00);
        wr(9'h15d, 8'h02);
        // Every code acts as one cycle: lag 1 inside, lag 2 outside
        for (int i = 0; i < 4; i++) begin
            wr(9'h15b, {2'(i), 6'h14});
            run_pairs(2, 3'h1);
            chk("lock", 11'h1, 11'(lock));
            chk("pin_oe", 11'h0, 11'(pin_oe));
            run_pairs(1, 3'h2);
            chk("lock", 11'h0, 11'(lock));
            chk("pin_oe", 11'h1, 11'(pin_oe));
        end
        $display("test window done");
        // Count 256 needs the high byte: 255 pairs short, 256 locks
        wr(9'h15c, 8'h01);
        wr(9'h15d, 8'h00);
        run_pairs(255, 3'h0);
        chk("lock", 11'h0, 11'(lock));
        run_pairs(1, 3'h0);
        chk("lock", 11'h1, 11'(lock));
        // Status: pull-up high, last comparison in, locked; count saturated
        rd(9'h1e0, 8'h07);
        rd(9'h1e1, 8'h01);
        rd(9'h1e2, 8'h00);
        wr(9'h15f, 8'h0b);
        @(negedge clk);
        chk("pin_o", 11'h1, 11'(pin_o));
        rd(9'h15f, 8'h0b);
        wr(9'h15f, 8'h03);
        @(negedge clk);
        chk("pin_o", 11'h0, 11'(pin_o));
        // Inverted push-pull of the low source drives high
        wr(9'h15f, 8'h04);
        @(negedge clk);
        chk("pin_o", 11'h1, 11'(pin_o));
        chk("pin_oe", 11'h1, 11'(pin_oe));
        run_pairs(1, 3'h3);
        chk("lock", 11'h0, 11'(lock));
        // Reserved zero count must never lock
        wr(9'h15c, 8'h00);
        wr(9'h15d, 8'h00);
        run_pairs(4, 3'h0);
        chk("lock", 11'h0, 11'(lock));
        $display("test count done");
        stop_test();
    end
endmodule : pld_top_test
